// ==== design/tog_pkg.sv ====
package tog_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] TOG_CTRL_OFS = 12'h000;
   localparam logic [31:0] TOG_CTRL_RST = 32'h0000_0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int TOG_EN_POS = 0;
   localparam int TOG_INV_POS = 1;
   localparam int TOG_SEL_LSB = 2;
   localparam int TOG_DIV_LSB = 4;
   localparam int TOG_BYP_POS = 15;
   localparam int TOG_PSC_LSB = 16;

   localparam logic [1:0] TOG_SEL_LSI = 2'h2;
   localparam logic [1:0] TOG_SEL_LSE = 2'h3;

   typedef struct packed {
      logic [5:0] bus_clock_prescale;
      logic second_stage_skip;
      logic [8:0] tone_divide_factor;
      logic [1:0] source_clock_select;
      logic complement_output_enable;
      logic tone_enable;
   } tog_ctrl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tog_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tog_apb_rsp_t;

   function automatic logic [31:0] tog_pack(input tog_ctrl_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[TOG_EN_POS] = c.tone_enable;
      w[TOG_INV_POS] = c.complement_output_enable;
      w[TOG_SEL_LSB +: 2] = c.source_clock_select;
      w[TOG_DIV_LSB +: 9] = c.tone_divide_factor;
      w[TOG_BYP_POS] = c.second_stage_skip;
      w[TOG_PSC_LSB +: 6] = c.bus_clock_prescale;
      return w;
   endfunction : tog_pack

   function automatic tog_ctrl_t tog_unpack(input logic [31:0] w);
      tog_ctrl_t c;
      c.tone_enable = w[TOG_EN_POS];
      c.complement_output_enable = w[TOG_INV_POS];
      c.source_clock_select = w[TOG_SEL_LSB +: 2];
      c.tone_divide_factor = w[TOG_DIV_LSB +: 9];
      c.second_stage_skip = w[TOG_BYP_POS];
      c.bus_clock_prescale = w[TOG_PSC_LSB +: 6];
      return c;
   endfunction : tog_unpack

endpackage : tog_pkg

// ==== design/tog_tone_output_generator.sv ====
`timescale 1ns/1ps
module tog_tone_output_generator (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire tog_pkg::tog_apb_req_t apb_req,
   output tog_pkg::tog_apb_rsp_t apb_rsp,
   input wire logic low_speed_internal_osc,
   input wire logic low_speed_external_osc,
   output logic tone_out_primary,
   output logic tone_out_inverted
);
   import tog_pkg::*;

   typedef struct packed {
      tog_ctrl_t ctrl;
      logic [5:0] psc_cnt;
      logic [8:0] div_cnt;
      logic ls_lvl;
      logic ls_prev;
      logic out_p;
      logic out_n;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tog_state_t;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   tog_state_t st_q;
   tog_state_t st_d;
   logic mapped;
   logic setup;
   logic wr;
   logic sel_ls;
   logic ls_tick;
   logic psc_tick;
   logic stage_tick;
   logic stage_lvl;
   logic wave;

   always_comb
   begin
      st_d = st_q;
      mapped = (apb_req.paddr[11:2] == TOG_CTRL_OFS[11:2]);
      setup = apb_req.psel & ~apb_req.penable;
      wr = apb_req.psel & apb_req.penable & apb_req.pwrite & st_q.pready & mapped;

      // Ready rises in the access phase, so every transfer takes two cycles
      st_d.pready = setup;
      st_d.pslverr = setup & ~mapped;
      st_d.prdata = (setup & ~apb_req.pwrite & mapped) ? tog_pack(st_q.ctrl) : 32'h0000_0000;
      if (wr)
         st_d.ctrl = tog_unpack(apb_req.pwdata);

      // Slow clocks are sampled, so they must be well below the bus clock
      sel_ls = st_q.ctrl.source_clock_select[1];
      st_d.ls_lvl = (st_q.ctrl.source_clock_select == TOG_SEL_LSE) ?
                    low_speed_external_osc : low_speed_internal_osc;
      st_d.ls_prev = st_q.ls_lvl;
      ls_tick = st_q.ls_lvl & ~st_q.ls_prev;

      // At or past the field, so lowering it while running wraps at once, not after 64
      psc_tick = (st_q.psc_cnt >= st_q.ctrl.bus_clock_prescale);
      stage_tick = sel_ls ? ls_tick : psc_tick;
      stage_lvl = sel_ls ? st_q.ls_lvl : (st_q.psc_cnt == 6'h00);
      wave = st_q.out_p;

      if (!st_q.ctrl.tone_enable)
      begin
         st_d.psc_cnt = 6'h00;
         st_d.div_cnt = 9'h000;
         wave = 1'b0;
      end
      else
      begin
         st_d.psc_cnt = psc_tick ? 6'h00 : st_q.psc_cnt + 6'h01;
         if (st_q.ctrl.second_stage_skip)
         begin
            st_d.div_cnt = 9'h000;
            wave = stage_lvl;
         end
         else if (stage_tick)
         begin
            // Same catch-up compare, or a lowered divide field runs on to 511 first
            if (st_q.div_cnt >= st_q.ctrl.tone_divide_factor)
            begin
               st_d.div_cnt = 9'h000;
               wave = ~st_q.out_p;
            end
            else
               st_d.div_cnt = st_q.div_cnt + 9'h001;
         end
      end
      st_d.out_p = wave;
      st_d.out_n = st_q.ctrl.tone_enable & st_q.ctrl.complement_output_enable
                   & ~wave;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
         st_q.ctrl <= tog_unpack(TOG_CTRL_RST);
      end
      else
         st_q <= st_d;
   end

   assign apb_rsp.prdata = st_q.prdata;
   assign apb_rsp.pready = st_q.pready;
   assign apb_rsp.pslverr = st_q.pslverr;
   assign tone_out_primary = st_q.out_p;
   assign tone_out_inverted = st_q.out_n;

   // ----------------------------------------
   // Checks: register bus
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   ready_pulse_a: assert property (
      st_q.pready |=> !st_q.pready)
      else $error("ready held past the access cycle");

   read_data_a: assert property (
      setup && !apb_req.pwrite && mapped |=> st_q.prdata == tog_pack(st_q.ctrl))
      else $error("read data does not match control register");

   unmapped_error_a: assert property (
      setup && !mapped |=> st_q.pready && st_q.pslverr)
      else $error("unmapped access not flagged");

   // ----------------------------------------
   // Checks: tone outputs
   // ----------------------------------------
   idle_when_off_a: assert property (
      !st_q.ctrl.tone_enable ##1 !st_q.ctrl.tone_enable
      |-> !tone_out_primary && !tone_out_inverted)
      else $error("outputs active while disabled");

   complement_pair_a: assert property (
      st_q.ctrl.tone_enable && st_q.ctrl.complement_output_enable
      ##1 $stable(st_q.ctrl) |-> tone_out_inverted == !tone_out_primary)
      else $error("outputs not complementary");

   single_output_a: assert property (
      !st_q.ctrl.complement_output_enable
      ##1 !st_q.ctrl.complement_output_enable |-> !tone_out_inverted)
      else $error("inverted output active while complement off");

   shared_config_a: assert property (
      st_q.ctrl.tone_enable && st_q.ctrl.complement_output_enable
      |=> tone_out_inverted != tone_out_primary)
      else $error("inverted output not derived from primary");

   skip_slow_a: assert property (
      st_q.ctrl.tone_enable && st_q.ctrl.second_stage_skip && sel_ls
      |=> tone_out_primary == $past(st_q.ls_lvl))
      else $error("skipped slow clock not passed through");

   skip_bus_pulse_a: assert property (
      st_q.ctrl.tone_enable && st_q.ctrl.second_stage_skip && !sel_ls
      |=> tone_out_primary == ($past(st_q.psc_cnt) == 6'h00))
      else $error("skipped bus clock not passed as prescaler pulse");

   skip_div_hold_a: assert property (
      st_q.ctrl.tone_enable && st_q.ctrl.second_stage_skip
      |=> st_q.div_cnt == 9'h000)
      else $error("second stage ran while skipped");

   prescale_wrap_a: assert property (
      st_q.ctrl.tone_enable && psc_tick && $stable(st_q.ctrl)
      |=> st_q.psc_cnt == 6'h00)
      else $error("prescaler did not wrap at terminal count");

   prescale_limit_a: assert property (
      st_q.ctrl.tone_enable && $stable(st_q.ctrl)
      |-> st_q.psc_cnt <= st_q.ctrl.bus_clock_prescale)
      else $error("prescaler exceeds prescale field");

   off_counters_a: assert property (
      !st_q.ctrl.tone_enable
      |=> st_q.psc_cnt == 6'h00 && st_q.div_cnt == 9'h000)
      else $error("dividers ran while disabled");

   toggle_terminal_a: assert property (
      st_q.ctrl.tone_enable && !st_q.ctrl.second_stage_skip && stage_tick
      && st_q.div_cnt == st_q.ctrl.tone_divide_factor
      |=> tone_out_primary != $past(tone_out_primary))
      else $error("no toggle at divide terminal count");

   hold_between_a: assert property (
      st_q.ctrl.tone_enable && !st_q.ctrl.second_stage_skip
      && !stage_tick && $stable(st_q.ctrl) |=> $stable(tone_out_primary))
      else $error("output changed without a stage tick");

endmodule : tog_tone_output_generator

// ==== verification/tog_beeper_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Passive beeper: times each level of the drive across its coil
// ----------------------------------------
module tog_beeper_model (
   input wire logic clk_sys,
   input wire logic tone_out_primary,
   input wire logic tone_out_inverted,
   output logic [15:0] hi_len,
   output logic [15:0] lo_len
);
   logic coil;
   logic prev_q = 1'b0;
   logic [15:0] run_q = 16'h0001;
   // The coil sees the difference of its two ends: positive only while the primary
   // is high and the inverted end is not, so a broken complement shows as no tone
   assign coil = tone_out_primary & ~tone_out_inverted;
   always_ff @(posedge clk_sys)
   begin
      prev_q <= coil;
      if (coil === prev_q)
         run_q <= run_q + 16'h0001;
      else
      begin
         if (prev_q)
            hi_len <= run_q;
         else
            lo_len <= run_q;
         run_q <= 16'h0001;
      end
   end
endmodule : tog_beeper_model

// ==== verification/tog_tone_output_generator_bench.sv ====
`timescale 1ns/1ps
module tog_tone_output_generator_bench;
   import tog_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic low_speed_internal_osc = 1'b0;
   logic low_speed_external_osc = 1'b0;
   tog_apb_req_t req = '0;
   tog_apb_rsp_t rsp;
   logic pri, inv, err;
   logic [15:0] hi_len, lo_len;
   logic [31:0] rd;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] cfg [5] = '{32'h0002_0013, 32'h0000_0007, 32'h0002_8003, 32'h0000_800B,
      32'h0000_001F};
   logic [15:0] exp_hi [5] = '{16'h0006, 16'h0001, 16'h0001, 16'h000A, 16'h0040};
   logic [15:0] exp_lo [5] = '{16'h0006, 16'h0001, 16'h0002, 16'h000A, 16'h0040};

   tog_tone_output_generator u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .apb_req(req),
      .apb_rsp(rsp), .low_speed_internal_osc(low_speed_internal_osc),
      .low_speed_external_osc(low_speed_external_osc), .tone_out_primary(pri),
      .tone_out_inverted(inv));
   tog_beeper_model u_beeper (.clk_sys(clk_sys), .tone_out_primary(pri),
      .tone_out_inverted(inv), .hi_len(hi_len), .lo_len(lo_len));

   initial forever #12.5 clk_sys = ~clk_sys;
   // Slow clocks: exactly 20 and 32 bus cycles per period, moving on falling edges only
   initial forever #250 low_speed_internal_osc = ~low_speed_internal_osc;
   initial forever #400 low_speed_external_osc = ~low_speed_external_osc;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   // Registered response stands from the edge after setup to the edge ending the access
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      req = '{1'b1, 1'b0, w, a, d};
      @(negedge clk_sys);
      check("pready", {31'h0, rsp.pready}, 32'h1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.penable = 1'b1;
      @(negedge clk_sys);
      req = '0;
   endtask : xfer

   task automatic hold_check(input logic [31:0] want_inv, input logic [31:0] flip);
      repeat (8)
      begin
         @(negedge clk_sys);
         check("inverted output", {31'h0, inv}, want_inv ^ (flip & {31'h0, ~pri}));
      end
   endtask : hold_check

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (10) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      xfer(1'b0, TOG_CTRL_OFS, 32'h0);
      check("reset value", rd, TOG_CTRL_RST);
      xfer(1'b1, 12'h004, 32'hFFFF_FFFF);
      check("unmapped error", {31'h0, err}, 32'h1);
      xfer(1'b1, TOG_CTRL_OFS, 32'hFFFF_FFFF);
      xfer(1'b0, TOG_CTRL_OFS, 32'h0);
      check("field mask", rd, 32'h003F_9FFF);
      $display("test registers done");
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b1, TOG_CTRL_OFS, 32'h0);
         xfer(1'b1, TOG_CTRL_OFS, cfg[i]);
         repeat (300) @(negedge clk_sys);
         check("high time", {16'h0, hi_len}, {16'h0, exp_hi[i]});
         check("low time", {16'h0, lo_len}, {16'h0, exp_lo[i]});
         hold_check(32'h0, 32'h1);
         $display("test tone %0d done", i);
      end
      xfer(1'b1, TOG_CTRL_OFS, 32'h0000_0005);
      hold_check(32'h0, 32'h0);
      xfer(1'b1, TOG_CTRL_OFS, 32'h0);
      repeat (2) @(negedge clk_sys);
      repeat (8)
      begin
         @(negedge clk_sys);
         check("idle outputs", {30'h0, pri, inv}, 32'h0);
      end
      $display("test single and idle done");
      xfer(1'b1, TOG_CTRL_OFS, 32'h0000_0007);
      repeat (5) @(negedge clk_sys);
      reset_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      check("outputs in reset", {30'h0, pri, inv}, 32'h0);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      xfer(1'b0, TOG_CTRL_OFS, 32'h0);
      check("value after reset", rd, TOG_CTRL_RST);
      $display("test reset in run done");
      report_and_stop();
   end
endmodule : tog_tone_output_generator_bench
